// ### hdl/bpse_pkg.sv
package bpse_pkg;

  // Sizes of the stack machinery
  localparam int              NUM_PROC   = 4;          // Logical processors
  localparam int              PROC_W     = 2;          // Processor index width
  localparam int              ADDR_W     = 16;         // Shared RAM address width
  localparam int              PTR_W      = 8;          // Stack pointer width
  localparam int              BYTE_W     = 8;          // Data byte width

  // Values after reset
  localparam logic [7:0]      DSP_RESET  = 8'h00;      // Data stack starts low
  localparam logic [7:0]      RSP_RESET  = 8'hFF;      // Return stack starts high
  localparam logic [7:0]      TOS_RESET  = 8'h00;      // Top of data stack
  localparam logic [15:0]     IP_RESET   = 16'h0000;   // Instruction pointer
  localparam logic [15:0]     BP_STRIDE  = 16'h0100;   // Reset spacing of base pages
  localparam logic [15:0]     PAGE_LAST  = 16'h00FF;   // Last offset inside a base page

  // Processor roles and clock threshold
  localparam logic [1:0]      APP_PROC   = 2'h2;       // Application processor
  localparam logic [1:0]      ISR_PROC   = 2'h3;       // Interrupt processor
  localparam int              ISR_MIN_CLK_MHZ = 20;    // Least clock for interrupt processor

  // Stack commands
  typedef enum logic [2:0] {
    CMD_PUSH  = 3'h0,   // Push byte on data stack
    CMD_POP   = 3'h1,   // Pop byte from data stack
    CMD_CALL  = 3'h2,   // Subroutine call
    CMD_RET   = 3'h3,   // Subroutine return
    CMD_RPUSH = 3'h4,   // Temporary byte onto return stack
    CMD_RPOP  = 3'h5,   // Temporary byte off return stack
    CMD_PEEK  = 3'h6,   // Fetch next data stack entry
    CMD_SETBP = 3'h7    // Load base page pointer
  } bpse_op_t;

  // Command from the core
  typedef struct packed {
    bpse_op_t          op;       // Command
    logic [1:0]        proc;     // Requesting processor
    logic [7:0]        data;     // Byte to push
    logic [15:0]       target;   // Call target or base page
  } bpse_cmd_t;

  // Request to the shared RAM
  typedef struct packed {
    logic              req;      // Access this cycle
    logic              we;       // Write when high
    logic [15:0]       addr;     // Byte address
    logic [7:0]        wdata;    // Write data
  } bpse_mem_req_t;

  // Register view of one processor
  typedef struct packed {
    logic [15:0]       base_page_pointer;
    logic [15:0]       instruction_pointer;
    logic [7:0]        data_stack_pointer;
    logic [7:0]        return_stack_pointer;
    logic [7:0]        top_of_data_stack;
  } bpse_view_t;

  // Pointer step that wraps inside the page
  function automatic logic [7:0] bpse_ptr_step(input logic [7:0] ptr, input logic up);
    bpse_ptr_step = up ? 8'(ptr + 8'h01) : 8'(ptr - 8'h01);
  endfunction

endpackage

// ### hdl/bpse_addr_gen.sv
`timescale 1ns/1ns
// Forms a RAM address from a base page and a pointer offset
module bpse_addr_gen
  import bpse_pkg::*;
(
  input  wire logic [15:0] base,     // Base page pointer
  input  wire logic [7:0]  offset,   // Stack pointer
  output logic      [15:0] addr      // Base plus offset
);

  // Zero extended sum, carry out of 16 bits dropped
  assign addr = 16'(base + {8'h00, offset});

endmodule // bpse_addr_gen

// ### hdl/bpse_core.sv
`timescale 1ns/1ns
// Summary of operation
// - Base page up to 256 bytes at pointer
// - Each processor keeps a distinct base page
// - ALU operands are top byte and next
// - Top in register, next at base+pointer
// - Data stack grows toward higher addresses
// - Push: increment, store top, load new
// - Pop: deliver top, reload, then decrement
// - Return stack grows toward lower addresses
// - Call: high, decrement, low, decrement, jump
// - Return: increment, low, increment, high
// - Return stack also holds temporary bytes
// - Three processors plus interrupt processor
// - Interrupt processor only at 20 MHz up
// - Base page pointer is 16 bits
// - Stack pointers are 8 bits each
module bpse_core
  import bpse_pkg::*;
#(
  parameter int CLK_FREQ_MHZ = 100                // System clock rate
)(
  input  wire logic          sys_clk,             // System clock
  input  wire logic          rst,                 // Synchronous reset
  input  wire logic          cmd_valid,           // Command offered
  input  wire bpse_cmd_t     cmd,                 // Command fields
  output logic               cmd_ready,           // Engine idle
  output bpse_mem_req_t      mem,                 // Shared RAM request
  input  wire logic [7:0]    mem_rdata,           // Read data, one cycle after req
  output logic               done,                // Command finished
  output logic               cmd_refused,         // Base page load refused
  output logic [7:0]         pop_data,            // Popped byte
  output logic [7:0]         next_data,           // Next data stack entry
  input  wire logic [1:0]    view_proc,           // Processor to observe
  output bpse_view_t         view                 // Its registers
);

  // One-hot sequencer states
  typedef enum logic [14:0] {
    S_IDLE      = 15'h0001,
    S_PUSH_WR   = 15'h0002,
    S_POP_RD    = 15'h0004,
    S_POP_WT    = 15'h0008,
    S_CALL_HI   = 15'h0010,
    S_CALL_LO   = 15'h0020,
    S_RET_RD_LO = 15'h0040,
    S_RET_WT_LO = 15'h0080,
    S_RET_RD_HI = 15'h0100,
    S_RET_WT_HI = 15'h0200,
    S_RPUSH_WR  = 15'h0400,
    S_RPOP_RD   = 15'h0800,
    S_RPOP_WT   = 15'h1000,
    S_PEEK_RD   = 15'h2000,
    S_PEEK_WT   = 15'h4000
  } bpse_state_t;

  // Interrupt processor exists only at the faster rates
  localparam logic ISR_EN = (CLK_FREQ_MHZ >= ISR_MIN_CLK_MHZ);

  // Per processor register sets
  logic [15:0]       bp_q  [NUM_PROC];           // Base page pointers
  logic [15:0]       ip_q  [NUM_PROC];           // Instruction pointers
  logic [7:0]        dsp_q [NUM_PROC];           // Data stack pointers
  logic [7:0]        rsp_q [NUM_PROC];           // Return stack pointers
  logic [7:0]        tos_q [NUM_PROC];           // Top of data stack

  // Sequencer state
  bpse_state_t       st_r, st_nxt;               // Current and next state
  logic [1:0]        cur_r;                      // Processor being served
  logic [7:0]        data_r, data_nxt;           // Byte held for the sequence
  logic [15:0]       tgt_r, tgt_nxt;             // Call target held
  logic [7:0]        pop_r, pop_nxt;             // Popped byte
  logic [7:0]        next_r, next_nxt;           // Fetched next entry
  logic              done_r, done_nxt;           // Finish pulse
  logic              ref_r, ref_nxt;             // Refusal pulse
  bpse_view_t        view_r;                     // Registered view

  // Values of the selected processor
  logic [15:0]       bp_nxt, ip_nxt;
  logic [7:0]        dsp_nxt, rsp_nxt, tos_nxt;
  bpse_mem_req_t     mem_c;                      // Combinational RAM request

  // Decoding wires
  wire               accept   = cmd_valid && cmd_ready;
  wire  [1:0]        eff_proc = (!ISR_EN && cmd.proc == ISR_PROC) ? APP_PROC
                                                                  : cmd.proc;
  wire  [1:0]        sel      = (st_r == S_IDLE) ? eff_proc : cur_r;
  wire  [15:0]       sel_bp   = bp_q[sel];
  wire  [15:0]       sel_ip   = ip_q[sel];
  wire  [7:0]        sel_dsp  = dsp_q[sel];
  wire  [7:0]        sel_rsp  = rsp_q[sel];
  wire  [7:0]        sel_tos  = tos_q[sel];
  logic [15:0]       addr_ds;                    // Base plus data stack pointer
  logic [15:0]       addr_rs;                    // Base plus return stack pointer
  logic              bp_clash;                   // New base page already in use
  logic              bp_unique;                  // All base pages differ

  // Address of the next data stack entry
  bpse_addr_gen u_addr_ds (
    .base   (sel_bp),
    .offset (sel_dsp),
    .addr   (addr_ds)
  );

  // Address of the return stack slot
  bpse_addr_gen u_addr_rs (
    .base   (sel_bp),
    .offset (sel_rsp),
    .addr   (addr_rs)
  );

  // Base page clash and uniqueness checks
  always_comb begin
    bp_clash  = 1'b0;
    bp_unique = 1'b1;
    for (int i = 0; i < NUM_PROC; i++) begin
      // Another processor already owns this page
      if (PROC_W'(i) != eff_proc && bp_q[i] == cmd.target) begin
        bp_clash = 1'b1;
      end
      for (int j = i + 1; j < NUM_PROC; j++) begin
        if (bp_q[i] == bp_q[j]) begin
          bp_unique = 1'b0;
        end
      end
    end
  end

  // Sequencer next state and register values
  always_comb begin
    st_nxt   = st_r;
    bp_nxt   = sel_bp;
    ip_nxt   = sel_ip;
    dsp_nxt  = sel_dsp;
    rsp_nxt  = sel_rsp;
    tos_nxt  = sel_tos;
    data_nxt = data_r;
    tgt_nxt  = tgt_r;
    pop_nxt  = pop_r;
    next_nxt = next_r;
    done_nxt = 1'b0;
    ref_nxt  = 1'b0;
    mem_c    = '0;
    case (st_r)
      S_IDLE: begin
        if (accept) begin
          case (cmd.op)
            // Step pointer up before storing the old top
            CMD_PUSH: begin
              dsp_nxt  = bpse_ptr_step(sel_dsp, 1'b1);
              data_nxt = cmd.data;
              st_nxt   = S_PUSH_WR;
            end
            // Deliver the top byte first
            CMD_POP: begin
              pop_nxt = sel_tos;
              st_nxt  = S_POP_RD;
            end
            // Keep the target until both bytes are stored
            CMD_CALL: begin
              tgt_nxt = cmd.target;
              st_nxt  = S_CALL_HI;
            end
            // Step up to the low byte
            CMD_RET: begin
              rsp_nxt = bpse_ptr_step(sel_rsp, 1'b1);
              st_nxt  = S_RET_RD_LO;
            end
            // Temporary byte kept for the store
            CMD_RPUSH: begin
              data_nxt = cmd.data;
              st_nxt   = S_RPUSH_WR;
            end
            // Step up to the last stored byte
            CMD_RPOP: begin
              rsp_nxt = bpse_ptr_step(sel_rsp, 1'b1);
              st_nxt  = S_RPOP_RD;
            end
            // Fetch the second operand
            CMD_PEEK: begin
              st_nxt = S_PEEK_RD;
            end
            // Load a base page unless another processor holds it
            default: begin
              if (bp_clash) begin
                ref_nxt = 1'b1;
              end else begin
                bp_nxt   = cmd.target;
                done_nxt = 1'b1;
              end
            end
          endcase
        end
      end
      // Old top goes to memory, new byte to the register
      S_PUSH_WR: begin
        mem_c    = '{req: 1'b1, we: 1'b1, addr: addr_ds, wdata: sel_tos};
        tos_nxt  = data_r;
        done_nxt = 1'b1;
        st_nxt   = S_IDLE;
      end
      // Read the entry under the top
      S_POP_RD: begin
        mem_c  = '{req: 1'b1, we: 1'b0, addr: addr_ds, wdata: 8'h00};
        st_nxt = S_POP_WT;
      end
      // Reload the top, then step the pointer down
      S_POP_WT: begin
        tos_nxt  = mem_rdata;
        dsp_nxt  = bpse_ptr_step(sel_dsp, 1'b0);
        done_nxt = 1'b1;
        st_nxt   = S_IDLE;
      end
      // High byte of the return address first
      S_CALL_HI: begin
        mem_c   = '{req: 1'b1, we: 1'b1, addr: addr_rs, wdata: sel_ip[15:8]};
        rsp_nxt = bpse_ptr_step(sel_rsp, 1'b0);
        st_nxt  = S_CALL_LO;
      end
      // Low byte, then jump
      S_CALL_LO: begin
        mem_c    = '{req: 1'b1, we: 1'b1, addr: addr_rs, wdata: sel_ip[7:0]};
        rsp_nxt  = bpse_ptr_step(sel_rsp, 1'b0);
        ip_nxt   = tgt_r;
        done_nxt = 1'b1;
        st_nxt   = S_IDLE;
      end
      // Read the low byte of the return address
      S_RET_RD_LO: begin
        mem_c  = '{req: 1'b1, we: 1'b0, addr: addr_rs, wdata: 8'h00};
        st_nxt = S_RET_WT_LO;
      end
      // Take low byte, step up to the high byte
      S_RET_WT_LO: begin
        ip_nxt  = {sel_ip[15:8], mem_rdata};
        rsp_nxt = bpse_ptr_step(sel_rsp, 1'b1);
        st_nxt  = S_RET_RD_HI;
      end
      // Read the high byte
      S_RET_RD_HI: begin
        mem_c  = '{req: 1'b1, we: 1'b0, addr: addr_rs, wdata: 8'h00};
        st_nxt = S_RET_WT_HI;
      end
      // Take high byte
      S_RET_WT_HI: begin
        ip_nxt   = {mem_rdata, sel_ip[7:0]};
        done_nxt = 1'b1;
        st_nxt   = S_IDLE;
      end
      // Temporary byte stored like a call byte
      S_RPUSH_WR: begin
        mem_c    = '{req: 1'b1, we: 1'b1, addr: addr_rs, wdata: data_r};
        rsp_nxt  = bpse_ptr_step(sel_rsp, 1'b0);
        done_nxt = 1'b1;
        st_nxt   = S_IDLE;
      end
      // Read the temporary byte
      S_RPOP_RD: begin
        mem_c  = '{req: 1'b1, we: 1'b0, addr: addr_rs, wdata: 8'h00};
        st_nxt = S_RPOP_WT;
      end
      // Hand the temporary byte out
      S_RPOP_WT: begin
        pop_nxt  = mem_rdata;
        done_nxt = 1'b1;
        st_nxt   = S_IDLE;
      end
      // Read the second operand from memory
      S_PEEK_RD: begin
        mem_c  = '{req: 1'b1, we: 1'b0, addr: addr_ds, wdata: 8'h00};
        st_nxt = S_PEEK_WT;
      end
      // Hold it for the arithmetic unit
      S_PEEK_WT: begin
        next_nxt = mem_rdata;
        done_nxt = 1'b1;
        st_nxt   = S_IDLE;
      end
      default: begin
        st_nxt = S_IDLE;
      end
    endcase
  end

  // State and register update
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r   <= S_IDLE;
      cur_r  <= '0;
      data_r <= 8'h00;
      tgt_r  <= 16'h0000;
      pop_r  <= 8'h00;
      next_r <= 8'h00;
      done_r <= 1'b0;
      ref_r  <= 1'b0;
      view_r <= '0;
      for (int i = 0; i < NUM_PROC; i++) begin
        bp_q[i]  <= 16'(16'(i) * BP_STRIDE);
        ip_q[i]  <= IP_RESET;
        dsp_q[i] <= DSP_RESET;
        rsp_q[i] <= RSP_RESET;
        tos_q[i] <= TOS_RESET;
      end
    end else begin
      st_r       <= st_nxt;
      cur_r      <= sel;
      data_r     <= data_nxt;
      tgt_r      <= tgt_nxt;
      pop_r      <= pop_nxt;
      next_r     <= next_nxt;
      done_r     <= done_nxt;
      ref_r      <= ref_nxt;
      bp_q[sel]  <= bp_nxt;
      ip_q[sel]  <= ip_nxt;
      dsp_q[sel] <= dsp_nxt;
      rsp_q[sel] <= rsp_nxt;
      tos_q[sel] <= tos_nxt;
      view_r     <= '{bp_q[view_proc], ip_q[view_proc], dsp_q[view_proc],
                      rsp_q[view_proc], tos_q[view_proc]};
    end
  end

  // Outputs
  assign cmd_ready   = (st_r == S_IDLE);
  assign mem         = mem_c;
  assign done        = done_r;
  assign cmd_refused = ref_r;
  assign pop_data    = pop_r;
  assign next_data   = next_r;
  assign view        = view_r;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_push_store;
    st_r == S_PUSH_WR && mem.req && mem.we && mem.addr == addr_ds;
  endsequence

  sequence s_ret_reads;
    (mem.req && !mem.we) ##1 !mem.req ##1 (mem.req && !mem.we) ##1 !mem.req;
  endsequence

  push_order_a: assert property (accept && cmd.op == CMD_PUSH |=>
    s_push_store ##1 (done && tos_q[cur_r] == $past(cmd.data, 2)))
    else $error("push sequence wrong");
  dsp_up_a: assert property (accept && cmd.op == CMD_PUSH |=>
    dsp_q[cur_r] == 8'($past(sel_dsp) + 8'h01))
    else $error("data stack pointer did not rise");
  pop_order_a: assert property (accept && cmd.op == CMD_POP |=>
    pop_data == $past(sel_tos) ##2
    (done && dsp_q[cur_r] == 8'($past(sel_dsp, 3) - 8'h01)))
    else $error("pop sequence wrong");
  call_order_a: assert property (accept && cmd.op == CMD_CALL |=>
    (mem.we && mem.wdata == sel_ip[15:8]) ##1 (mem.we && mem.wdata == sel_ip[7:0])
    ##1 (done && ip_q[cur_r] == $past(cmd.target, 3)))
    else $error("call sequence wrong");
  rsp_down_a: assert property (st_r == S_CALL_HI |=>
    sel_rsp == 8'($past(sel_rsp) - 8'h01))
    else $error("return stack pointer did not fall");
  ret_order_a: assert property (accept && cmd.op == CMD_RET |=>
    s_ret_reads ##1 (done && ip_q[cur_r] == {$past(mem_rdata, 1), $past(mem_rdata, 3)}))
    else $error("return sequence wrong");
  rs_temp_a: assert property (accept && cmd.op == CMD_RPUSH |=>
    mem.we && mem.wdata == $past(cmd.data) && mem.addr == addr_rs)
    else $error("temporary byte not stored");
  page_bound_a: assert property (mem.req |->
    16'(mem.addr - sel_bp) <= PAGE_LAST)
    else $error("access outside base page");
  bp_unique_a: assert property (bp_unique)
    else $error("base pages overlap");
  isr_map_a: assert property (!ISR_EN && accept |=> cur_r != ISR_PROC)
    else $error("interrupt processor used at low clock");
  peek_next_a: assert property (accept && cmd.op == CMD_PEEK |->
    ##3 (done && next_data == $past(mem_rdata, 1)))
    else $error("next entry not fetched");

endmodule // bpse_core

// ### testbench/bpse_ram_model.sv
`timescale 1ns/1ns
// Shared RAM behind the stack engine, one cycle read latency
module bpse_ram_model
  import bpse_pkg::*;
(
  input  wire logic          sys_clk,   // System clock
  input  wire bpse_mem_req_t mem,       // Request from the engine
  output logic [7:0]         mem_rdata  // Read data, one cycle after req
);
  logic [7:0] mem_a [0:65535];          // Byte storage

  // Fill with a pattern so a stored zero is mistaken for untouched only where the low address byte is A5
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem_a[i] = 8'(i) ^ 8'hA5;
    end
    mem_rdata = 8'h00;
  end

  // Writes land at the edge; reads answer for one cycle, then the bus flips
  always @(posedge sys_clk) begin
    if (mem.req && mem.we) begin
      mem_a[mem.addr] <= mem.wdata;
    end
    if (mem.req && !mem.we) begin
      mem_rdata <= mem_a[mem.addr];
    end else begin
      mem_rdata <= ~mem_rdata;          // Stale data is never left standing
    end
  end
endmodule // bpse_ram_model

// ### testbench/tb.sv
`timescale 1ns/1ns
// Self-checking bench of the stack engine
module tb;
  import bpse_pkg::*;
  logic          sys_clk;          // System clock
  logic          rst;              // Synchronous reset
  logic          cmd_valid;        // Command offered
  bpse_cmd_t     cmd;              // Command fields
  logic [1:0]    view_proc;        // Processor observed
  logic          cmd_ready;        // Engine idle
  bpse_mem_req_t mem;              // RAM request
  bpse_mem_req_t mem2;             // RAM request, slow clock engine
  logic [7:0]    mem_rdata;        // RAM read data
  logic [7:0]    mem_rdata2;       // RAM read data, slow clock engine
  logic          done;             // Command finished
  logic          cmd_refused;      // Base page load refused
  logic [7:0]    pop_data;         // Popped byte
  logic [7:0]    next_data;        // Next data entry
  bpse_view_t    view;             // Register view
  bpse_view_t    view2;            // Register view, slow clock engine
  int            n_fail;           // Mismatches
  int            samples_checked;  // Comparisons

  bpse_core #(.CLK_FREQ_MHZ(100)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .mem(mem), .mem_rdata(mem_rdata), .done(done),
    .cmd_refused(cmd_refused), .pop_data(pop_data), .next_data(next_data),
    .view_proc(view_proc), .view(view));
  bpse_ram_model i_ram (.sys_clk(sys_clk), .mem(mem), .mem_rdata(mem_rdata));

  // Second engine below the clock threshold, fed the same commands
  bpse_core #(.CLK_FREQ_MHZ(10)) i_dut2 (
    .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(), .mem(mem2), .mem_rdata(mem_rdata2), .done(),
    .cmd_refused(), .pop_data(), .next_data(),
    .view_proc(view_proc), .view(view2));
  bpse_ram_model i_ram2 (.sys_clk(sys_clk), .mem(mem2), .mem_rdata(mem_rdata2));

  // Clock generator
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Verdict and stop
  task automatic end_sim();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compare one value
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Issue one command and time its completion from the accept edge
  task automatic run(input bpse_op_t op, input logic [1:0] p, input logic [7:0] d,
                     input logic [15:0] t, input int lat, input logic refused);
    int n;
    n = 0;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd       <= '{op: op, proc: p, data: d, target: t};
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    // Looked at just after each edge, so pass i shows what edge i-1 after accept samples, pass 1 the accept edge itself
    for (int i = 1; i <= 20 && n == 0; i++) begin
      #1;
      if (done === 1'b1 || cmd_refused === 1'b1) begin
        n = i;
      end else begin
        @(posedge sys_clk);
      end
    end
    if (n == 0) begin
      n_fail++;
      $display("[ERR] completion expected %0d seen none", lat);
      end_sim();
    end else begin
      chk("latency", 16'(lat), 16'(n));
      chk("refused", {15'h0000, refused}, {15'h0000, cmd_refused});
    end
  endtask

  // Select a processor view and let it settle
  task automatic look(input logic [1:0] p);
    @(posedge sys_clk);
    view_proc <= p;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  // Reset state of every processor
  task automatic t_reset();
    for (int p = 0; p < 4; p++) begin
      look(2'(p));
      chk("bp", 16'(p * 256), view.base_page_pointer);
      chk("ip", 16'h0000, view.instruction_pointer);
      chk("dsp", 16'h0000, {8'h00, view.data_stack_pointer});
      chk("rsp", 16'h00FF, {8'h00, view.return_stack_pointer});
      chk("tos", 16'h0000, {8'h00, view.top_of_data_stack});
    end
  endtask

  // Two pushes, peek, then two pops
  task automatic t_data_stack();
    run(CMD_PUSH, 2'h0, 8'h3C, 16'h0000, 2, 1'b0);
    run(CMD_PUSH, 2'h0, 8'hC3, 16'h0000, 2, 1'b0);
    chk("push1", 16'h0000, {8'h00, i_ram.mem_a[16'h0001]});
    chk("push2", 16'h003C, {8'h00, i_ram.mem_a[16'h0002]});
    look(2'h0);
    chk("tos", 16'h00C3, {8'h00, view.top_of_data_stack});
    chk("dsp", 16'h0002, {8'h00, view.data_stack_pointer});
    run(CMD_PEEK, 2'h0, 8'h00, 16'h0000, 3, 1'b0);
    chk("next", 16'h003C, {8'h00, next_data});
    run(CMD_POP, 2'h0, 8'h00, 16'h0000, 3, 1'b0);
    chk("pop", 16'h00C3, {8'h00, pop_data});
    look(2'h0);
    chk("tos", 16'h003C, {8'h00, view.top_of_data_stack});
    chk("dsp", 16'h0001, {8'h00, view.data_stack_pointer});
    run(CMD_POP, 2'h0, 8'h00, 16'h0000, 3, 1'b0);
    look(2'h0);
    chk("pop", 16'h003C, {8'h00, pop_data});
    chk("tos", 16'h0000, {8'h00, view.top_of_data_stack});
  endtask

  // Nested calls, a return, and one temporary byte pushed and popped on the return stack
  task automatic t_return_stack();
    run(CMD_CALL, 2'h1, 8'h00, 16'h1234, 3, 1'b0);
    run(CMD_CALL, 2'h1, 8'h00, 16'hABCD, 3, 1'b0);
    chk("ip_hi", 16'h0012, {8'h00, i_ram.mem_a[16'h01FD]});
    chk("ip_lo", 16'h0034, {8'h00, i_ram.mem_a[16'h01FC]});
    look(2'h1);
    chk("ip", 16'hABCD, view.instruction_pointer);
    chk("rsp", 16'h00FB, {8'h00, view.return_stack_pointer});
    run(CMD_RET, 2'h1, 8'h00, 16'h0000, 5, 1'b0);
    look(2'h1);
    chk("ip", 16'h1234, view.instruction_pointer);
    chk("rsp", 16'h00FD, {8'h00, view.return_stack_pointer});
    run(CMD_RPUSH, 2'h1, 8'h5A, 16'h0000, 2, 1'b0);
    chk("temp", 16'h005A, {8'h00, i_ram.mem_a[16'h01FD]});
    run(CMD_RPOP, 2'h1, 8'h00, 16'h0000, 3, 1'b0);
    chk("temp_pop", 16'h005A, {8'h00, pop_data});
  endtask

  // Interrupt processor present at full rate, folded onto app below 20 MHz
  task automatic t_isr_proc();
    run(CMD_PUSH, 2'h3, 8'h77, 16'h0000, 2, 1'b0);
    chk("isr_page", 16'h0000, {8'h00, i_ram.mem_a[16'h0301]});
    chk("slow_app", 16'h0000, {8'h00, i_ram2.mem_a[16'h0201]});
    chk("slow_isr", 16'h00A4, {8'h00, i_ram2.mem_a[16'h0301]});
    look(2'h2);
    chk("slow_tos", 16'h0077, {8'h00, view2.top_of_data_stack});
  endtask

  // Clashing base page refused, then a page whose top wraps the address
  task automatic t_base_page();
    run(CMD_SETBP, 2'h2, 8'h00, 16'h0100, 1, 1'b1);
    look(2'h2);
    chk("bp_kept", 16'h0200, view.base_page_pointer);
    run(CMD_SETBP, 2'h2, 8'h00, 16'hFFF8, 1, 1'b0);
    run(CMD_RPUSH, 2'h2, 8'h99, 16'h0000, 2, 1'b0);
    chk("wrap", 16'h0099, {8'h00, i_ram.mem_a[16'h00F7]});
    look(2'h2);
    chk("bp_new", 16'hFFF8, view.base_page_pointer);
  endtask

  // Main sequence
  initial begin
    n_fail          = 0;
    samples_checked = 0;
    rst             = 1'b1;
    cmd_valid       = 1'b0;
    cmd             = '0;
    view_proc       = 2'h0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_data_stack();
    t_return_stack();
    t_isr_proc();
    t_base_page();
    end_sim();
  end
endmodule // tb
